// ---- rtl/gate_host_consts.svh ----
`ifndef GATE_HOST_CONSTS_SVH
`define GATE_HOST_CONSTS_SVH

// Reference clock period in ns
`define REF_CLK_PERIOD_NS 20
// Least low time of the fault-clear pulse in ns
`define CLEAR_PULSE_NS 3000
`define CLEAR_PULSE_CYC \
  ((`CLEAR_PULSE_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
// Settle time between gate-off and clear in ns
`define SETTLE_NS 200
`define SETTLE_CYC \
  ((`SETTLE_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
// Mode codes
`define MODE_NONINV 2'h0
`define MODE_INV 2'h1
`define MODE_AUTO 2'h2
`define MODE_INV_SHUT 2'h3

`endif

// ---- rtl/gate_host_pkg.sv ----
`default_nettype none
package gate_host_pkg;
  typedef enum logic [1:0] {
    MODE_NONINV = 2'h0,
    MODE_INV = 2'h1,
    MODE_AUTO = 2'h2,
    MODE_INV_SHUT = 2'h3
  } drive_mode_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_FAULT = 2'h1,
    ST_SETTLE = 2'h2,
    ST_CLEAR = 2'h3
  } clear_state_e;

  typedef struct packed {
    logic gate_cmd_noninv;
    logic gate_cmd_inv;
    logic fault_clear_n;
  } pin_out_s;
endpackage
`default_nettype wire

// ---- rtl/gate_host.sv ----
`include "gate_host_consts.svh"
`default_nettype none
module gate_host
  import gate_host_pkg::*;
#(
  parameter int unsigned NDRV = 1,
  parameter int unsigned CLEAR_CYC = `CLEAR_PULSE_CYC,
  parameter int unsigned SETTLE_CYC = `SETTLE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic [NDRV-1:0] pwm,
  input wire logic clear_req,
  input wire logic [NDRV-1:0] fault_n,
  output logic [NDRV-1:0] gate_cmd_noninv,
  output logic [NDRV-1:0] gate_cmd_inv,
  output logic [NDRV-1:0] fault_clear_n,
  output logic [NDRV-1:0] fault_seen,
  output logic busy
);

  localparam int CW = $clog2(CLEAR_CYC + SETTLE_CYC + 2);

  clear_state_e st_q [NDRV];
  logic [CW-1:0] cnt_q [NDRV];
  logic [NDRV-1:0] busy_v;

  function automatic pin_out_s drive(input logic [1:0] m, input logic p,
                                     input logic flt_n, input logic off);
    pin_out_s r;
    r.fault_clear_n = 1'b1;
    unique case (m)
      `MODE_NONINV: begin
        r.gate_cmd_noninv = p & ~off;
        r.gate_cmd_inv = 1'b0;
      end
      `MODE_INV: begin
        r.gate_cmd_noninv = 1'b1;
        r.gate_cmd_inv = ~p | off;
      end
      `MODE_AUTO: begin
        r.gate_cmd_noninv = p;
        r.gate_cmd_inv = 1'b0;
        r.fault_clear_n = p;
      end
      `MODE_INV_SHUT: begin
        r.gate_cmd_noninv = flt_n & ~off;
        r.gate_cmd_inv = ~p | off;
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < NDRV; g++) begin : g_drv
      pin_out_s po;
      logic hold_off;
      // gate held off while fault latched or being cleared
      assign hold_off = (st_q[g] != ST_RUN);
      assign po = drive(mode, pwm[g], fault_n[g], hold_off);
      assign busy_v[g] = hold_off;

      // per-driver poll and clear; fault seen on low line
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          st_q[g] <= ST_RUN;
          cnt_q[g] <= '0;
        end else if (mode == `MODE_AUTO) begin
          st_q[g] <= ST_RUN;
          cnt_q[g] <= '0;
        end else begin
          unique case (st_q[g])
            ST_RUN: if (!fault_n[g]) st_q[g] <= ST_FAULT;
            ST_FAULT: begin
              if (clear_req) begin
                st_q[g] <= ST_SETTLE;
                cnt_q[g] <= CW'(SETTLE_CYC);
              end
            end
            ST_SETTLE: begin
              if (cnt_q[g] <= CW'(1)) begin
                st_q[g] <= ST_CLEAR;
                cnt_q[g] <= CW'(CLEAR_CYC);
              end else begin
                cnt_q[g] <= cnt_q[g] - CW'(1);
              end
            end
            ST_CLEAR: begin
              if (cnt_q[g] <= CW'(1)) begin
                if (fault_n[g]) st_q[g] <= ST_RUN;
              end else begin
                cnt_q[g] <= cnt_q[g] - CW'(1);
              end
            end
          endcase
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          gate_cmd_noninv[g] <= 1'b0;
          gate_cmd_inv[g] <= 1'b0;
          fault_clear_n[g] <= 1'b1;
          fault_seen[g] <= 1'b0;
        end else begin
          gate_cmd_noninv[g] <= po.gate_cmd_noninv;
          gate_cmd_inv[g] <= po.gate_cmd_inv;
          fault_clear_n[g] <= po.fault_clear_n & (st_q[g] != ST_CLEAR);
          fault_seen[g] <= ~fault_n[g];
        end
      end

      property p_off_before_clear;
        @(posedge ref_clk) disable iff (rst)
        (mode != `MODE_AUTO) && $fell(fault_clear_n[g]) |->
          (gate_cmd_noninv[g] == 1'b0) || (gate_cmd_inv[g] == 1'b1);
      endproperty
      a_off_before_clear: assert property (p_off_before_clear)
        else $error("clear asserted while gate commanded on");

      property p_fault_shut;
        @(posedge ref_clk) disable iff (rst)
        (mode == `MODE_INV_SHUT) && !fault_n[g] |=> !gate_cmd_noninv[g];
      endproperty
      a_fault_shut: assert property (p_fault_shut)
        else $error("fault did not pull enable low");

      property p_auto_clear;
        @(posedge ref_clk) disable iff (rst)
        (mode == `MODE_AUTO) |=> fault_clear_n[g] == $past(pwm[g]);
      endproperty
      a_auto_clear: assert property (p_auto_clear)
        else $error("auto clear does not follow command");

      property p_noninv_pins;
        @(posedge ref_clk) disable iff (rst)
        (mode == `MODE_NONINV) |=> !gate_cmd_inv[g];
      endproperty
      a_noninv_pins: assert property (p_noninv_pins)
        else $error("inverting input not low");

      property p_inv_pins;
        @(posedge ref_clk) disable iff (rst)
        (mode == `MODE_INV) |=> gate_cmd_noninv[g];
      endproperty
      a_inv_pins: assert property (p_inv_pins)
        else $error("non-inverting input not high");

      sequence s_fault_run;
        (mode == `MODE_NONINV) && (st_q[g] == ST_RUN) && !fault_n[g];
      endsequence
      property p_fault_stop;
        @(posedge ref_clk) disable iff (rst)
        s_fault_run ##1 (mode == `MODE_NONINV) |=> !gate_cmd_noninv[g];
      endproperty
      a_fault_stop: assert property (p_fault_stop)
        else $error("gate commanded on after fault");

      property p_poll;
        @(posedge ref_clk) disable iff (rst)
        !fault_n[g] |=> fault_seen[g];
      endproperty
      a_poll: assert property (p_poll)
        else $error("fault not reported");

      sequence s_settling;
        (mode != `MODE_AUTO) && (st_q[g] == ST_SETTLE);
      endsequence
      property p_settle_high;
        @(posedge ref_clk) disable iff (rst)
        s_settling |-> fault_clear_n[g];
      endproperty
      a_settle_high: assert property (p_settle_high)
        else $error("clear asserted before gate settled off");

      sequence s_enter_clear;
        s_settling ##1 (st_q[g] == ST_CLEAR);
      endsequence
      property p_clear_low;
        @(posedge ref_clk) disable iff (rst)
        s_enter_clear |=> !fault_clear_n[g];
      endproperty
      a_clear_low: assert property (p_clear_low)
        else $error("clear not pulled low for faulted driver");

      // Outside auto mode, clear stays released unless this driver has faulted
      property p_run_clear_high;
        @(posedge ref_clk) disable iff (rst)
        (mode != `MODE_AUTO) && (st_q[g] == ST_RUN) |=> fault_clear_n[g];
      endproperty
      a_run_clear_high: assert property (p_run_clear_high)
        else $error("clear pulled low without a fault");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= |busy_v;
    end
  end

endmodule
`default_nettype wire

// ---- testbench/gate_dev_model.sv ----
`default_nettype none
module gate_dev_model #(
  // Least fault pulse, 3 us of 20 ns cycles
  parameter int MIN_CYC = 150
) (
  input wire logic ref_clk,
  input wire logic noninv,
  input wire logic inv,
  input wire logic clr_n,
  input wire logic [15:0] sat_mv,
  input wire logic lockout,
  output logic fault_oe_n,
  output logic gate_out,
  output logic clr_conflict
);
  timeunit 1ns;
  timeprecision 1ns;
  logic latch_q = 1'b0;
  logic conflict_q = 1'b0;
  int age_q = 0;
  always @(posedge ref_clk) begin
    if (sat_mv > 16'h1B58 && gate_out) latch_q <= 1'b1;
    else if (!clr_n && age_q >= MIN_CYC) latch_q <= 1'b0;
  end
  always @(posedge ref_clk) age_q <= latch_q ? age_q + 1 : 0;
  assign fault_oe_n = ~latch_q;
  assign gate_out = noninv & ~inv & ~latch_q & ~lockout;
  always @(posedge ref_clk) begin
    if (!clr_n && noninv && !inv) conflict_q <= 1'b1;
  end
  assign clr_conflict = conflict_q;
endmodule
`default_nettype wire

// ---- testbench/gate_host_test.sv ----
`default_nettype none
module gate_host_test;
  import gate_host_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst = 1, clear_req = 0, lockout = 0;
  logic [1:0] mode = 2'h0, pwm = 2'h0;
  logic [15:0] sat [2] = '{16'h0000, 16'h0000};
  logic [1:0] noninv, inv, clr_n, seen, oe_n, gate, bad;
  logic busy;
  int n_fail = 0, n_checks = 0, cnt;
  int lo_run = 0, lo_last = 0;
  localparam int PULSE_MIN = 150;
  localparam int WAIT_MAX = 400;
  always #10 ref_clk = ~ref_clk;
  gate_host #(.NDRV(2), .CLEAR_CYC(4), .SETTLE_CYC(2)) gate_host_inst (
    .ref_clk(ref_clk), .rst(rst), .mode(mode), .pwm(pwm),
    .clear_req(clear_req), .fault_n(oe_n), .gate_cmd_noninv(noninv),
    .gate_cmd_inv(inv), .fault_clear_n(clr_n), .fault_seen(seen),
    .busy(busy));
  // Pull-up: line is high unless the model pulls
  for (genvar i = 0; i < 2; i++) begin : g_dev
    gate_dev_model #(.MIN_CYC(150)) gate_dev_model_inst (
      .ref_clk(ref_clk), .noninv(noninv[i]), .inv(inv[i]),
      .clr_n(clr_n[i]), .sat_mv(sat[i]), .lockout(lockout),
      .fault_oe_n(oe_n[i]), .gate_out(gate[i]), .clr_conflict(bad[i]));
  end
  function automatic logic [1:0] exp_inv(logic [1:0] m, logic [1:0] p);
    return (m == 2'h1 || m == 2'h3) ? ~p : 2'h0;
  endfunction
  // Sequencer holds off only in the manual modes
  function automatic logic [1:0] exp_busy(logic [1:0] m);
    return (m == 2'h2) ? 2'h0 : 2'h1;
  endfunction
  // Length of the last low pulse on fault line 0
  always @(posedge ref_clk) begin
    if (!oe_n[0]) begin
      lo_run <= lo_run + 1;
    end else if (lo_run != 0) begin
      lo_last <= lo_run;
      lo_run <= 0;
    end
  end
  task automatic chk(string what, logic [1:0] exp, logic [1:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1ms;
    n_fail++;
    stop_test();
  end
  initial begin
    void'($urandom(54409));
    step(6);
    chk("reset cmd", 2'h0, noninv | inv);
    chk("reset clear_n", 2'h3, clr_n);
    chk("reset seen", 2'h0, seen);
    chk("reset busy", 2'h0, {1'b0, busy});
    rst <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      mode <= 2'(m);
      for (int k = 0; k < 4; k++) begin
        step(1);
        pwm <= 2'($urandom);
        sat[1] <= (k == 0) ? 16'h1B58 : 16'($urandom % 32'h1B59);
        step(3);
        #1;
        chk("inv", exp_inv(mode, pwm), inv);
        if (mode == 2'h2) chk("clear_n", pwm, clr_n);
        if (mode == 2'h1) chk("noninv", 2'h3, noninv);
        chk("gate", pwm, gate);
        chk("seen", 2'h0, seen);
      end
      step(1);
      pwm <= 2'h3;
      lockout <= 1'b1;
      step(3);
      #1;
      chk("gate", 2'h0, gate);
      step(1);
      lockout <= 1'b0;
      step(3);
      sat[0] <= 16'h1B59 + 16'($urandom % 32'h384);
      step(6);
      #1;
      chk("seen", 2'h1, seen);
      chk("gate", 2'h2, gate);
      chk("clear_n", 2'h3, clr_n);
      if (mode == 2'h3) chk("noninv", 2'h2, noninv & 2'h2);
      chk("busy", exp_busy(mode), {1'b0, busy});
      step(1);
      sat[0] <= 16'h0000;
      clear_req <= 1'b1;
      pwm <= 2'h2;
      cnt = 0;
      while ((seen[0] !== 1'b0 || busy !== 1'b0) && cnt < WAIT_MAX) begin
        step(1);
        cnt++;
      end
      if (cnt == WAIT_MAX) begin
        n_fail++;
        stop_test();
      end
      clear_req <= 1'b0;
      step(3);
      #1;
      chk("fault_n", 2'h3, oe_n);
      chk("pulse", 2'h1, {1'b0, lo_last >= PULSE_MIN});
      chk("gate", 2'h2, gate);
      chk("conflict", 2'h0, bad);
      step(1);
    end
    stop_test();
  end
endmodule
`default_nettype wire
